// ===== inc/acfg_pkg.sv
`default_nettype none
package acfg_pkg;
  // clock and link timing
  localparam int CLK_HZ       = 20_000_000;
  localparam int SLOW_MAX_HZ  = 20_000_000;
  localparam int FAST_MAX_HZ  = 40_000_000;
  localparam int SYNC_DEPTH   = 2;
  // a half period never shorter than the input synchroniser delay
  localparam int FAST_HALF    = SYNC_DEPTH +
    (CLK_HZ + 2 * FAST_MAX_HZ - 1) / (2 * FAST_MAX_HZ);
  localparam int SLOW_HALF    = 2 * FAST_HALF;
  localparam int DIV_W        = 4;
  localparam logic [DIV_W-1:0] FAST_HALF_CYC = DIV_W'(FAST_HALF);
  localparam logic [DIV_W-1:0] SLOW_HALF_CYC = DIV_W'(SLOW_HALF);

  // flash read sequence
  localparam int          ADDR_W     = 24;
  localparam int          CMD_BITS   = 32;
  localparam logic [7:0]  READ_CMD   = 8'h03;
  localparam logic [4:0]  LAST_CMD_FALL = 5'h1F;
  localparam logic [2:0]  LAST_BIT   = 3'h7;

  // decompression and configuration memory
  localparam logic [7:0]  RUN_MARKER = 8'h00;
  localparam int          CFG_ADDR_W = 20;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;

  typedef enum logic [1:0] {
    ACFG_SCHEME_ACTIVE_SERIAL,
    ACFG_SCHEME_PASSIVE_SERIAL,
    ACFG_SCHEME_ACTIVE_PARALLEL,
    ACFG_SCHEME_FAST_PARALLEL
  } acfg_scheme_t;

  typedef enum logic [1:0] {
    ACFG_CLK_SLOW,
    ACFG_CLK_FAST,
    ACFG_CLK_USER
  } acfg_clksrc_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } acfg_sclk_t;

  typedef struct packed {
    logic                  valid;
    logic [CFG_ADDR_W-1:0] addr;
    logic [7:0]            data;
  } acfg_cfg_write_t;
endpackage
`default_nettype wire

// ===== hw/acfg_sclk_gen.sv
`timescale 1ns/100ps
`default_nettype none
module acfg_sclk_gen (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // control
  input  wire logic                  run_i,
  input  wire acfg_pkg::acfg_clksrc_t src_i,
  input  wire logic                  user_clock_in_i,
  // generated serial clock
  output acfg_pkg::acfg_sclk_t       sclk_o
);
  import acfg_pkg::*;

  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic [1:0]       user_sync;
  logic             next_level;
  logic [DIV_W-1:0] half;
  acfg_sclk_t       next_sclk;

  ////////////////////////////////////////////////////////////////////
  // a stopped clock still finishes its high phase, so it parks low
  always_comb begin
    half         = (src_i == ACFG_CLK_SLOW) ? SLOW_HALF_CYC : FAST_HALF_CYC;
    next_level   = sclk_o.level;
    next_div_cnt = div_cnt;
    if (src_i == ACFG_CLK_USER) begin
      next_div_cnt = '0;
      if (run_i || !user_sync[1]) begin
        next_level = user_sync[1];
      end
    end else if (run_i || sclk_o.level) begin
      if (div_cnt >= half - 4'h1) begin
        next_div_cnt = '0;
        next_level   = !sclk_o.level;
      end else begin
        next_div_cnt = div_cnt + 4'h1;
      end
    end else begin
      next_div_cnt = '0;
    end
    next_sclk.level = next_level;
    next_sclk.rise  = next_level && !sclk_o.level;
    next_sclk.fall  = !next_level && sclk_o.level;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt   <= '0;
      user_sync <= '0;
      sclk_o    <= '0;
    end else begin
      div_cnt   <= next_div_cnt;
      user_sync <= {user_sync[0], user_clock_in_i};
      sclk_o    <= next_sclk;
    end
  end
endmodule
`default_nettype wire

// ===== hw/acfg_master.sv
// What this block does
// - master shifts, decompresses, writes configuration cells
// - reconfig low tristates, enable high only blocks the start
// - four wire flash link clock data select command
// - device generates the serial clock itself
// - slow fast or user clock source selectable
// - drive flash select low while configuring
// - command and address shifted out serially
// - after configuration pins released to pull-ups
// - chain enable out low after own data
// - chain enable pin free after configuration
// - first device masters the whole chain
// - status and complete are open drain
// - release complete when own data done
// - complete high starts initialization together
// - select and command pins have parallel roles
// - boundary scan configuration overrides scheme select
`timescale 1ns/100ps
`default_nettype none
module acfg_master (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // straps and control
  input  wire logic                    reconfig_request_n_i,
  input  wire logic                    chip_enable_in_n_i,
  input  wire logic [1:0]              scheme_select_i,
  input  wire logic                    boundary_scan_config_i,
  input  wire acfg_pkg::acfg_clksrc_t  clock_source_i,
  input  wire logic                    clock_options_enable_i,
  input  wire logic                    user_clock_in_i,
  input  wire logic [acfg_pkg::ADDR_W-1:0] start_address_i,
  input  wire logic [acfg_pkg::ADDR_W-1:0] own_bytes_i,
  input  wire logic                    compressed_i,
  // flash link
  output logic                         config_serial_clock_o,
  output logic                         config_serial_clock_oe_n_o,
  output logic                         flash_select_out_o,
  output logic                         flash_select_out_oe_n_o,
  output logic                         serial_command_out_o,
  output logic                         serial_command_out_oe_n_o,
  input  wire logic                    serial_command_out_i,
  input  wire logic                    serial_data_in_i,
  // parallel scheme roles
  input  wire logic                    parallel_flash_select_i,
  output logic                         parallel_data1_o,
  // chain
  output logic                         chain_enable_out_n_o,
  output logic                         chain_enable_out_oe_n_o,
  input  wire logic                    user_chain_io_i,
  input  wire logic                    user_chain_io_oe_n_i,
  // shared open-drain lines
  input  wire logic                    config_status_n_i,
  output logic                         config_status_n_o,
  output logic                         config_status_n_oe_n_o,
  input  wire logic                    config_complete_i,
  output logic                         config_complete_o,
  output logic                         config_complete_oe_n_o,
  // configuration memory and status
  output acfg_pkg::acfg_cfg_write_t    cfg_write_o,
  output logic                         init_start_o,
  output logic                         user_mode_o
);
  import acfg_pkg::*;

  typedef enum logic [2:0] {
    S_HOLD, S_IDLE, S_CMD, S_DATA, S_RUN, S_CHAIN, S_USER
  } acfg_state_t;

  ////////////////////////////////////////////////////////////////////
  // synchronisers for the reconfig, enable, scheme, data, status, complete and command pins
  logic [7:0] sync1;
  logic [7:0] sync2;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // reconfig reads low until the pin is seen, so we stay in hold
      sync1 <= 8'h7F;
      sync2 <= 8'h7F;
    end else begin
      sync1 <= {reconfig_request_n_i, chip_enable_in_n_i,
                scheme_select_i, serial_data_in_i,
                config_status_n_i, config_complete_i,
                serial_command_out_i};
      sync2 <= sync1;
    end
  end

  logic         reconfig_n_s;
  logic         ce_n_s;
  acfg_scheme_t scheme_s;
  logic         data_s;
  logic         status_n_s;
  logic         complete_s;

  assign reconfig_n_s     = sync2[7];
  assign ce_n_s           = sync2[6];
  assign scheme_s         = acfg_scheme_t'(sync2[5:4]);
  assign data_s           = sync2[3];
  assign status_n_s       = sync2[2];
  assign complete_s       = sync2[1];
  assign parallel_data1_o = sync2[0];

  ////////////////////////////////////////////////////////////////////
  // serial clock source
  acfg_state_t  state;
  acfg_clksrc_t src;
  acfg_sclk_t   sclk;
  logic         clk_run;

  // without the option only the fast internal oscillator exists
  assign src = clock_options_enable_i ? clock_source_i
                                      : ACFG_CLK_FAST;
  assign clk_run = (state == S_CMD) || (state == S_DATA) ||
                   (state == S_CHAIN);

  acfg_sclk_gen u_sclk_gen (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .run_i           (clk_run),
    .src_i           (src),
    .user_clock_in_i (user_clock_in_i),
    .sclk_o          (sclk)
  );

  ////////////////////////////////////////////////////////////////////
  // sequencer
  logic [CMD_BITS-1:0]   cmd_sr;
  logic [4:0]            fall_cnt;
  logic [2:0]            bit_cnt;
  logic [7:0]            shift;
  logic [7:0]            run_cnt;
  logic                  marker;
  logic [ADDR_W-1:0]     bytes_in;
  logic [CFG_ADDR_W-1:0] cfg_addr;
  acfg_cfg_write_t       cfg_wr;

  acfg_state_t           next_state;
  logic [CMD_BITS-1:0]   next_cmd_sr;
  logic [4:0]            next_fall_cnt;
  logic [2:0]            next_bit_cnt;
  logic [7:0]            next_shift;
  logic [7:0]            next_run_cnt;
  logic                  next_marker;
  logic [ADDR_W-1:0]     next_bytes_in;
  logic [CFG_ADDR_W-1:0] next_cfg_addr;
  acfg_cfg_write_t       next_cfg_wr;
  logic [7:0]            byte_done;
  logic                  own_done;

  always_comb begin
    next_state    = state;
    next_cmd_sr   = cmd_sr;
    next_fall_cnt = fall_cnt;
    next_bit_cnt  = bit_cnt;
    next_shift    = shift;
    next_run_cnt  = run_cnt;
    next_marker   = marker;
    next_bytes_in = bytes_in;
    next_cfg_addr = cfg_addr;
    next_cfg_wr   = '0;
    byte_done     = {shift[6:0], data_s};
    own_done      = (bytes_in + 24'h000001) >= own_bytes_i;
    unique case (state)
      S_HOLD: begin
        if (reconfig_n_s) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        // only the active-serial master at the chain head starts
        if (!boundary_scan_config_i && status_n_s && !ce_n_s &&
            scheme_s == ACFG_SCHEME_ACTIVE_SERIAL) begin
          next_state    = S_CMD;
          next_cmd_sr   = {READ_CMD, start_address_i};
          next_fall_cnt = '0;
          next_bit_cnt  = '0;
          next_bytes_in = '0;
          next_cfg_addr = '0;
          next_marker   = 1'b0;
        end
      end
      S_CMD: begin
        if (sclk.fall) begin
          next_fall_cnt = fall_cnt + 5'h01;
          next_cmd_sr   = {cmd_sr[CMD_BITS-2:0], 1'b0};
          if (fall_cnt == LAST_CMD_FALL) begin
            next_state = S_DATA;
          end
        end
      end
      S_DATA: begin
        if (sclk.fall) begin
          next_shift   = byte_done;
          next_bit_cnt = bit_cnt + 3'h1;
          if (bit_cnt == LAST_BIT) begin
            next_bytes_in = bytes_in + 24'h000001;
            if (compressed_i && marker) begin
              next_marker  = 1'b0;
              next_run_cnt = byte_done;
              next_state   = S_RUN;
            end else if (compressed_i && byte_done == RUN_MARKER) begin
              next_marker = 1'b1;
            end else begin
              next_cfg_wr.valid = 1'b1;
              next_cfg_wr.addr  = cfg_addr;
              next_cfg_wr.data  = byte_done;
              next_cfg_addr     = cfg_addr + 20'h00001;
            end
            if (own_done && !(compressed_i && marker)) begin
              next_state = S_CHAIN;
            end
          end
        end
      end
      S_RUN: begin
        // serial clock stalls while a run of zeros is expanded
        if (run_cnt != ZERO_BYTE) begin
          next_cfg_wr.valid = 1'b1;
          next_cfg_wr.addr  = cfg_addr;
          next_cfg_wr.data  = ZERO_BYTE;
          next_cfg_addr     = cfg_addr + 20'h00001;
          next_run_cnt      = run_cnt - 8'h01;
        end else if (bytes_in >= own_bytes_i) begin
          next_state = S_CHAIN;
        end else begin
          next_state = S_DATA;
        end
      end
      S_CHAIN: begin
        // keep clocking the flash so slaves get their share
        if (complete_s) begin
          next_state = S_USER;
        end
      end
      S_USER: begin
        next_state = S_USER;
      end
      default: begin
        next_state = S_HOLD;
      end
    endcase
    // an error reported on the shared status line restarts us
    if (!status_n_s && state != S_HOLD && state != S_USER &&
        state != S_IDLE) begin
      next_state = S_IDLE;
    end
    if (boundary_scan_config_i && state != S_HOLD) begin
      next_state = S_IDLE;
    end
    if (!reconfig_n_s) begin
      next_state = S_HOLD;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registered pin drive
  logic next_sclk_o;
  logic next_sclk_oe_n;
  logic next_sel_o;
  logic next_sel_oe_n;
  logic next_cmd_o;
  logic next_cmd_oe_n;
  logic next_cen_o;
  logic next_cen_oe_n;
  logic next_stat_oe_n;
  logic next_done_oe_n;
  logic next_init;
  logic link_active;

  always_comb begin
    link_active = (next_state == S_CMD) || (next_state == S_DATA) ||
                  (next_state == S_RUN) || (next_state == S_CHAIN);
    // pins float to their pull-ups whenever the link is idle, except select in active-parallel idle
    next_sclk_oe_n = !link_active;
    next_sel_oe_n  = !link_active;
    next_cmd_oe_n  = !link_active;
    next_sclk_o    = link_active && sclk.level;
    next_sel_o     = !link_active;
    next_cmd_o     = (next_state == S_CMD) && next_cmd_sr[CMD_BITS-1];
    if (next_state == S_IDLE && !boundary_scan_config_i &&
        scheme_s == ACFG_SCHEME_ACTIVE_PARALLEL) begin
      next_sel_oe_n = 1'b0;
      next_sel_o    = parallel_flash_select_i;
    end
    if (next_state == S_HOLD) begin
      next_sel_oe_n = 1'b1;
    end
    next_cen_o    = !(next_state == S_CHAIN || next_state == S_USER);
    next_cen_oe_n = 1'b0;
    if (next_state == S_USER) begin
      next_cen_o    = user_chain_io_i;
      next_cen_oe_n = user_chain_io_oe_n_i;
    end
    // open drain: only ever pull low, release otherwise
    next_stat_oe_n = next_state != S_HOLD;
    next_done_oe_n = (next_state == S_CHAIN) ||
                     (next_state == S_USER);
    next_init      = (next_state == S_USER) && (state != S_USER);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state                      <= S_HOLD;
      cmd_sr                     <= '0;
      fall_cnt                   <= '0;
      bit_cnt                    <= '0;
      shift                      <= '0;
      run_cnt                    <= '0;
      marker                     <= 1'b0;
      bytes_in                   <= '0;
      cfg_addr                   <= '0;
      cfg_wr                     <= '0;
      config_serial_clock_o      <= 1'b0;
      config_serial_clock_oe_n_o <= 1'b1;
      flash_select_out_o         <= 1'b1;
      flash_select_out_oe_n_o    <= 1'b1;
      serial_command_out_o       <= 1'b0;
      serial_command_out_oe_n_o  <= 1'b1;
      chain_enable_out_n_o       <= 1'b1;
      chain_enable_out_oe_n_o    <= 1'b0;
      config_status_n_oe_n_o     <= 1'b0;
      config_complete_oe_n_o     <= 1'b0;
      init_start_o               <= 1'b0;
    end else begin
      state                      <= next_state;
      cmd_sr                     <= next_cmd_sr;
      fall_cnt                   <= next_fall_cnt;
      bit_cnt                    <= next_bit_cnt;
      shift                      <= next_shift;
      run_cnt                    <= next_run_cnt;
      marker                     <= next_marker;
      bytes_in                   <= next_bytes_in;
      cfg_addr                   <= next_cfg_addr;
      cfg_wr                     <= next_cfg_wr;
      config_serial_clock_o      <= next_sclk_o;
      config_serial_clock_oe_n_o <= next_sclk_oe_n;
      flash_select_out_o         <= next_sel_o;
      flash_select_out_oe_n_o    <= next_sel_oe_n;
      serial_command_out_o       <= next_cmd_o;
      serial_command_out_oe_n_o  <= next_cmd_oe_n;
      chain_enable_out_n_o       <= next_cen_o;
      chain_enable_out_oe_n_o    <= next_cen_oe_n;
      config_status_n_oe_n_o     <= next_stat_oe_n;
      config_complete_oe_n_o     <= next_done_oe_n;
      init_start_o               <= next_init;
    end
  end

  // open-drain data is always zero; the enable does the work
  assign config_status_n_o = 1'b0;
  assign config_complete_o = 1'b0;
  assign cfg_write_o       = cfg_wr;
  assign user_mode_o       = state == S_USER;
endmodule
`default_nettype wire

// ===== test/acfg_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module acfg_flash_model (
  // serial link at the flash pins
  input  wire logic        sclk_i,
  input  wire logic        sel_n_i,
  input  wire logic        cmd_i,
  // stored bitstream, first byte in the top bits
  input  wire logic [63:0] image_i,
  // read data and captured command
  output logic             data_o,
  output logic [31:0]      cmd_o
);
  int          nbit;
  logic [63:0] shift;
  logic        bit_q;
  // deselect restarts, so an aborted read begins again at the command
  always @(posedge sclk_i or posedge sel_n_i) begin
    if (sel_n_i) begin
      nbit <= 0;
    end else if (nbit < 32) begin
      cmd_o <= {cmd_o[30:0], cmd_i};
      shift <= image_i;
      bit_q <= 1'b1;
      nbit <= nbit + 1;
    end else begin
      bit_q <= shift[63];
      shift <= {shift[62:0], ~shift[0]};
    end
  end
  // undriven line floats to the pull-up
  assign data_o = sel_n_i | bit_q;
endmodule
`default_nettype wire

// ===== test/acfg_master_checker.sv
`timescale 1ns/100ps
`default_nettype none
module acfg_master_checker (
  // clock and reset
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  // straps and pads
  input wire logic                 reconfig_request_n_i,
  input wire logic [1:0]           scheme_select_i,
  input wire logic                 boundary_scan_config_i,
  input wire acfg_pkg::acfg_clksrc_t clock_source_i,
  input wire logic                 serial_command_out_i,
  input wire logic                 config_complete_i,
  // outputs watched
  input wire logic                 config_serial_clock_o,
  input wire logic                 config_serial_clock_oe_n_o,
  input wire logic                 flash_select_out_o,
  input wire logic                 flash_select_out_oe_n_o,
  input wire logic                 serial_command_out_o,
  input wire logic                 serial_command_out_oe_n_o,
  input wire logic                 parallel_data1_o,
  input wire logic                 chain_enable_out_n_o,
  input wire logic                 config_status_n_o,
  input wire logic                 config_complete_o,
  input wire logic                 config_complete_oe_n_o,
  input wire acfg_pkg::acfg_cfg_write_t cfg_write_o,
  input wire logic                 init_start_o,
  input wire logic                 user_mode_o
);
  import acfg_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire as_off = config_serial_clock_oe_n_o & flash_select_out_oe_n_o &
    serial_command_out_oe_n_o;
  logic [CFG_ADDR_W-1:0] last_addr;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_addr <= '0;
    end else if (cfg_write_o.valid) begin
      last_addr <= cfg_write_o.addr;
    end
  end
  sequence s_high_phase;
    config_serial_clock_o [*2] ##1 !config_serial_clock_o;
  endsequence
  AST_OPEN_DRAIN: assert property (
    !config_status_n_o && !config_complete_o)
    else $error("open-drain output drives high");
  AST_HOLD_TRISTATE: assert property (
    !reconfig_request_n_i [*6] |-> as_off)
    else $error("link pins driven in hold");
  AST_SELECT_LOW: assert property (
    scheme_select_i == 2'h0 && !flash_select_out_oe_n_o |->
    !flash_select_out_o)
    else $error("select driven high");
  AST_CMD_CLK_LOW: assert property (
    $changed(serial_command_out_o) && !serial_command_out_oe_n_o &&
    !$past(serial_command_out_oe_n_o) |-> !config_serial_clock_o)
    else $error("command bit moved while clock high");
  AST_CLK_HALF: assert property (
    $rose(config_serial_clock_o) && clock_source_i == ACFG_CLK_FAST &&
    !config_serial_clock_oe_n_o |=> s_high_phase)
    else $error("fast clock high phase wrong");
  AST_CHAIN_RELEASE: assert property (
    $fell(chain_enable_out_n_o) && !user_mode_o |->
    ##[0:1] config_complete_oe_n_o)
    else $error("complete not released with chain enable");
  AST_INIT_BOUND: assert property (
    $rose(config_complete_i) && !chain_enable_out_n_o && !user_mode_o &&
    reconfig_request_n_i |-> ##[1:8] init_start_o)
    else $error("no init after complete rose");
  AST_USER_TRISTATE: assert property (
    user_mode_o && $past(user_mode_o) |-> as_off)
    else $error("link pins driven in user mode");
  AST_DONE_HELD: assert property (
    chain_enable_out_n_o && !user_mode_o |-> !config_complete_oe_n_o)
    else $error("complete released before own data");
  AST_ADDR_INC: assert property (
    cfg_write_o.valid && cfg_write_o.addr != '0 |->
    cfg_write_o.addr == last_addr + 1'b1)
    else $error("config address skipped");
  AST_JTAG_WINS: assert property (
    (boundary_scan_config_i && scheme_select_i == 2'h0) [*4] |->
    flash_select_out_oe_n_o)
    else $error("select driven under boundary scan");
  AST_PAR_DATA1: assert property (
    $stable(serial_command_out_i) [*3] |->
    parallel_data1_o == serial_command_out_i)
    else $error("parallel data bit does not follow pad");
endmodule
bind acfg_master acfg_master_checker i_chk (.*);
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import acfg_pkg::*;
  localparam logic [63:0] IMG_A = 64'hA53C00FF817E1122;
  localparam logic [63:0] IMG_B = 64'h5A0003C300000000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rcfg_n, ce_n, jtag, copt, uclk, comp, pfs, uio, uio_oe_n, peer_low;
  logic peer_err;
  logic sclk, sclk_oe_n, sel, sel_oe_n, cmd, cmd_oe_n, pd1, fdata;
  logic chain, chain_oe_n, st_o, st_oe_n, cd_o, cd_oe_n, init, umode;
  logic [1:0] sch;
  logic [ADDR_W-1:0] start, nbytes;
  logic [63:0] img;
  logic [31:0] fcmd;
  logic [7:0] got[$];
  acfg_clksrc_t src;
  acfg_cfg_write_t wr;
  int err_total, num_checks, n_init;
  // shared lines: pull-ups win unless someone drives
  wire sclk_w = sclk_oe_n | sclk;
  wire sel_w = sel_oe_n | sel;
  wire cmd_w = cmd_oe_n | cmd;
  wire st_w = (st_oe_n | st_o) & ~peer_err;
  wire cd_w = (cd_oe_n | cd_o) & ~peer_low;
  always #25 clk_i = ~clk_i;
  initial begin
    uclk = 1'b0;
    #7;
    forever #200 uclk = ~uclk;
  end
  acfg_master i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .reconfig_request_n_i(rcfg_n), .chip_enable_in_n_i(ce_n),
    .scheme_select_i(sch), .boundary_scan_config_i(jtag),
    .clock_source_i(src), .clock_options_enable_i(copt),
    .user_clock_in_i(uclk), .start_address_i(start),
    .own_bytes_i(nbytes), .compressed_i(comp),
    .config_serial_clock_o(sclk), .config_serial_clock_oe_n_o(sclk_oe_n),
    .flash_select_out_o(sel), .flash_select_out_oe_n_o(sel_oe_n),
    .serial_command_out_o(cmd), .serial_command_out_oe_n_o(cmd_oe_n),
    .serial_command_out_i(cmd_w), .serial_data_in_i(fdata),
    .parallel_flash_select_i(pfs), .parallel_data1_o(pd1),
    .chain_enable_out_n_o(chain), .chain_enable_out_oe_n_o(chain_oe_n),
    .user_chain_io_i(uio), .user_chain_io_oe_n_i(uio_oe_n),
    .config_status_n_i(st_w), .config_status_n_o(st_o),
    .config_status_n_oe_n_o(st_oe_n), .config_complete_i(cd_w),
    .config_complete_o(cd_o), .config_complete_oe_n_o(cd_oe_n),
    .cfg_write_o(wr), .init_start_o(init), .user_mode_o(umode));
  acfg_flash_model i_flash (.sclk_i(sclk_w), .sel_n_i(sel_w),
    .cmd_i(cmd_w), .image_i(img), .data_o(fdata), .cmd_o(fcmd));
  always @(posedge clk_i) begin
    if (wr.valid === 1'b1) begin
      got.push_back(wr.data);
    end
    if (init === 1'b1) begin
      n_init++;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what,
        seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic run(input string name, input logic [1:0] s,
      input acfg_clksrc_t c, input logic z, input int n,
      input logic [63:0] im, input logic pl, input logic ab);
    logic [7:0] exp[$];
    logic [7:0] b;
    logic rl;
    int t;
    int ni;
    rl = 1'b0;
    rcfg_n = 1'b0;
    ce_n = 1'b1;
    repeat (8) @(negedge clk_i);
    chk({sclk_oe_n, sel_oe_n, cmd_oe_n, st_oe_n}, 4'hE, "hold");
    sch = s;
    src = c;
    comp = z;
    nbytes = ADDR_W'(n);
    img = im;
    peer_low = pl;
    start = start + 24'h000100;
    got.delete();
    ni = n_init;
    rcfg_n = 1'b1;
    ce_n = 1'b0;
    if (s != 2'h0 || jtag) begin
      repeat (200) @(negedge clk_i);
      chk(sel_w, (s == 2'h2 && !jtag) ? pfs : 1'b1, "idle select");
      chk(got.size(), 0, "no loading");
      $display("test %s done", name);
      return;
    end
    if (ab) begin
      repeat (100) @(negedge clk_i);
      peer_err = 1'b1;
      repeat (4) @(negedge clk_i);
      chk(sel_oe_n, 1'b1, "status error stops link");
      peer_err = 1'b0;
      repeat (46) @(negedge clk_i);
      rcfg_n = 1'b0;
      ce_n = 1'b1;
      repeat (8) @(negedge clk_i);
      chk({sclk_oe_n, sel_oe_n, cmd_oe_n, st_oe_n}, 4'hE, "abort");
      got.delete();
      rcfg_n = 1'b1;
      ce_n = 1'b0;
    end
    for (t = 0; t < 20000 && chain !== 1'b0; t++) @(negedge clk_i);
    chk(chain, 1'b0, "chain enable");
    @(negedge clk_i);
    chk(cd_oe_n, 1'b1, "complete released");
    chk(fcmd, {READ_CMD, start}, "read command");
    for (int k = 0; k < n; k++) begin
      b = im[63 - 8 * k -: 8];
      if (rl) begin
        repeat (b) exp.push_back(ZERO_BYTE);
        rl = 1'b0;
      end else if (z && b == RUN_MARKER) begin
        rl = 1'b1;
      end else begin
        exp.push_back(b);
      end
    end
    chk(got.size(), exp.size(), "write count");
    foreach (exp[i]) chk(got[i], exp[i], "config byte");
    if (pl) begin
      repeat (30) @(negedge clk_i);
      chk(umode, 1'b0, "waits for shared complete");
      peer_low = 1'b0;
    end
    for (t = 0; t < 50 && umode !== 1'b1; t++) @(negedge clk_i);
    chk(umode, 1'b1, "user mode");
    repeat (3) @(negedge clk_i);
    chk(n_init - ni, 1, "one init pulse");
    chk({sclk_oe_n, sel_oe_n, cmd_oe_n}, 3'h7, "pins released");
    chk({chain, chain_oe_n}, {uio, uio_oe_n}, "chain pin free");
    $display("test %s done", name);
  endtask
  initial begin
    {rcfg_n, ce_n, jtag, copt, comp, pfs, uio, uio_oe_n} = 8'h5D;
    {peer_err, peer_low, sch, nbytes, img} = '0;
    src = ACFG_CLK_FAST;
    start = 24'h012300;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    run("fast plain", 2'h0, ACFG_CLK_FAST, 1'b0, 5, IMG_A, 1'b0, 1'b0);
    run("slow packed", 2'h0, ACFG_CLK_SLOW, 1'b1, 4, IMG_B, 1'b1, 1'b0);
    run("user abort", 2'h0, ACFG_CLK_USER, 1'b0, 3, IMG_A, 1'b0, 1'b1);
    jtag = 1'b1;
    run("boundary scan", 2'h0, ACFG_CLK_FAST, 1'b0, 2, IMG_A, 1'b0, 1'b0);
    jtag = 1'b0;
    // low so a driven select differs from the pull-up
    pfs = 1'b0;
    for (int s = 1; s < 4; s++) begin
      run("scheme", 2'(s), ACFG_CLK_FAST, 1'b0, 2, IMG_A, 1'b0, 1'b0);
    end
    test_done;
  end
  // longest run is under a thousand cycles, so this only trips on a hang
  initial begin
    #2_000_000;
    err_total++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    test_done;
  end
endmodule
`default_nettype wire
